//--- common/sflg_pkg.sv
/*
  Shared constants of the serial port status and flag block: register
  offsets, field positions, reset values and pin indices.
  Assumes an 8-bit register port and a single 125 MHz system clock.
*/
package sflg_pkg;
  ////////////////////////////////////////////////////////////////////////
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'hBC;
  localparam logic [7:0] ADDR_STAT = 8'hBD;
  localparam logic [7:0] ADDR_DATA = 8'hBE;
  localparam logic [7:0] ADDR_EVT = 8'hBF;
  localparam logic [7:0] ADDR_MASK = 8'hC0;
  ////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned CTRL_EN = 6;
  localparam int unsigned CTRL_SELECT_DISABLE = 5;
  localparam int unsigned CTRL_MASTER_SELECT_BIT = 4;
  localparam int unsigned CTRL_RATE_LO = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h73;
  // Status register fields
  localparam int unsigned STAT_DONE = 7;
  localparam int unsigned STAT_WRITE_COLLISION_FLAG = 6;
  localparam int unsigned STAT_MODF = 5;
  localparam int unsigned STAT_OVR = 4;
  localparam int unsigned STAT_RXF = 3;
  localparam int unsigned STAT_BUSY = 2;
  // Event status and mask fields
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_DONE = 0;
  localparam int unsigned EVT_WRITE_COLLISION_FLAG = 1;
  localparam int unsigned EVT_MODF = 2;
  localparam logic [2:0] EVT_RST = 3'h0;
  ////////////////////////////////////////////////////////////////////////
  // Synchronised pins
  localparam int unsigned NPIN = 4;
  localparam int unsigned PIN_SCLK = 0;
  localparam int unsigned PIN_MOSI = 1;
  localparam int unsigned PIN_MISO = 2;
  localparam int unsigned PIN_SS = 3;
endpackage

//--- hw/sflg_shift.sv
/*
  Shift engine: one byte per transfer, MSB first, clock idle low,
  sample on rising and change on falling edge.
  Assumes edge strobes of the external clock already synchronised.
*/
`timescale 1ns/1ps
module sflg_shift #(
  parameter int unsigned W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic master,
  input wire logic start,
  input wire logic [W-1:0] tx_data,
  input wire logic [1:0] rate_sel,
  input wire logic clk_rise,
  input wire logic clk_fall,
  input wire logic sel_active,
  input wire logic sdi,
  output logic sclk_out,
  output logic sdo,
  output logic busy,
  output logic done,
  output logic [W-1:0] rx_data
);
  logic [W-1:0] sh_r;
  logic [W-1:0] rx_sh_r;
  logic [2:0] cap_r;
  logic cap;
  logic drain_end;
  logic [3:0] cnt_r;
  logic [3:0] div_r;
  logic [3:0] half_m1;
  logic rise;
  logic fall;
  logic tick;

  ////////////////////////////////////////////////////////////////////////
  assign half_m1 = (4'h1 << rate_sel) - 4'h1;
  // Clock stops after the last falling edge while the returning bit drains
  assign tick = master && busy && (div_r == half_m1) && !(cnt_r == 4'(W) && !sclk_out);
  assign rise = master ? (tick && !sclk_out) : (sel_active && clk_rise);
  assign fall = master ? (tick && sclk_out) : (sel_active && clk_fall);
  // Returned data lags a master edge by the pin register and two sync stages
  assign cap = master ? cap_r[2] : rise;
  assign drain_end = master && busy && (cnt_r == 4'(W)) && !sclk_out && (cap_r == 3'h0);

  always_ff @(posedge clock) begin
    if (!rst_n || !enable || !master) begin
      cap_r <= 3'h0;
    end else begin
      cap_r <= {cap_r[1:0], rise};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_sh_r <= '0;
    end else if (cap) begin
      rx_sh_r <= {rx_sh_r[W-2:0], sdi};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !busy || tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !master || !enable) begin
      sclk_out <= 1'b0;
    end else if (tick) begin
      sclk_out <= !sclk_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave deselect aborts a partial byte so the next frame starts clean
  always_ff @(posedge clock) begin
    done <= 1'b0;
    if (!rst_n) begin
      busy <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= '0;
      sdo <= 1'b0;
      rx_data <= '0;
    end else if (!enable || (!master && !sel_active)) begin
      busy <= 1'b0;
      cnt_r <= 4'h0;
      if (start) begin
        sh_r <= tx_data;
        sdo <= tx_data[W-1];
      end
    end else if (start && !busy) begin
      sh_r <= tx_data;
      sdo <= tx_data[W-1];
      cnt_r <= 4'h0;
      busy <= master;
    end else if (rise) begin
      sh_r <= {sh_r[W-2:0], 1'b0};
      cnt_r <= cnt_r + 4'h1;
      busy <= 1'b1;
    end else if (fall && busy) begin
      if (cnt_r != 4'(W)) begin
        sdo <= sh_r[W-1];
      end else if (!master) begin
        busy <= 1'b0;
        done <= 1'b1;
        cnt_r <= 4'h0;
        rx_data <= rx_sh_r;
      end
    end else if (drain_end) begin
      busy <= 1'b0;
      done <= 1'b1;
      cnt_r <= 4'h0;
      rx_data <= rx_sh_r;
    end
  end
endmodule

//--- hw/sflg_top.sv
/*
  Serial port with its status and flag logic, register port and
  interrupt. Holds the pin synchronisers and the flag registers.
  Assumes a same-clock register master and pins from outside the domain.
*/
`timescale 1ns/1ps
module sflg_top #(
  parameter int unsigned W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic int_ack,
  output logic irq,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic ss_n_i
);
  logic [sflg_pkg::NPIN-1:0] pin_in;
  logic [sflg_pkg::NPIN-1:0] sync1_r;
  logic [sflg_pkg::NPIN-1:0] sync2_r;
  logic sclk_prev_r;
  logic clk_rise;
  logic clk_fall;
  logic sel_active;
  logic sdi;

  logic [7:0] ctrl_r;
  logic port_en;
  logic master;
  logic select_disable;

  logic done_r;
  logic write_collision_flag_r;
  logic modf_r;
  logic ovr_r;
  logic rxf_r;
  logic [2:0] evt_r;
  logic [2:0] mask_r;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic wr_evt;
  logic wr_mask;
  logic rd_data;
  logic start;
  logic modf_set;
  logic write_collision_flag_set;

  logic sh_sclk;
  logic sh_sdo;
  logic sh_busy;
  logic sh_done;
  logic [W-1:0] sh_rx;
  logic [7:0] stat_view;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is looked at
  assign pin_in[sflg_pkg::PIN_SCLK] = sclk_i;
  assign pin_in[sflg_pkg::PIN_MOSI] = mosi_i;
  assign pin_in[sflg_pkg::PIN_MISO] = miso_i;
  assign pin_in[sflg_pkg::PIN_SS] = ss_n_i;

  for (genvar i = 0; i < sflg_pkg::NPIN; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        sync1_r[i] <= (i == sflg_pkg::PIN_SS);
        sync2_r[i] <= (i == sflg_pkg::PIN_SS);
      end else begin
        sync1_r[i] <= pin_in[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sync2_r[sflg_pkg::PIN_SCLK];
    end
  end

  assign clk_rise = sync2_r[sflg_pkg::PIN_SCLK] && !sclk_prev_r;
  assign clk_fall = !sync2_r[sflg_pkg::PIN_SCLK] && sclk_prev_r;
  assign sel_active = !sync2_r[sflg_pkg::PIN_SS];
  assign sdi = master ? sync2_r[sflg_pkg::PIN_MISO] : sync2_r[sflg_pkg::PIN_MOSI];

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  assign wr_ctrl = reg_wr && (reg_addr == sflg_pkg::ADDR_CTRL);
  assign wr_stat = reg_wr && (reg_addr == sflg_pkg::ADDR_STAT);
  assign wr_data = reg_wr && (reg_addr == sflg_pkg::ADDR_DATA);
  assign wr_evt = reg_wr && (reg_addr == sflg_pkg::ADDR_EVT);
  assign wr_mask = reg_wr && (reg_addr == sflg_pkg::ADDR_MASK);
  assign rd_data = reg_rd && (reg_addr == sflg_pkg::ADDR_DATA);

  assign port_en = ctrl_r[sflg_pkg::CTRL_EN];
  assign master = ctrl_r[sflg_pkg::CTRL_MASTER_SELECT_BIT];
  assign select_disable = ctrl_r[sflg_pkg::CTRL_SELECT_DISABLE];

  // A write that collides is dropped, the byte in flight is kept
  assign write_collision_flag_set = wr_data && sh_busy;
  assign start = wr_data && !sh_busy && port_en;
  assign modf_set = port_en && master && !select_disable && sel_active;

  ////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r <= sflg_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata & sflg_pkg::CTRL_WMASK;
      end
      // Fault drops the port to a disabled slave before driving clashes
      if (modf_set) begin
        ctrl_r[sflg_pkg::CTRL_EN] <= 1'b0;
        ctrl_r[sflg_pkg::CTRL_MASTER_SELECT_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift engine
  sflg_shift #(
    .W(W)
  ) u_shift (
    .clock(clock),
    .rst_n(rst_n),
    .enable(port_en),
    .master(master),
    .start(start),
    .tx_data(reg_wdata[W-1:0]),
    .rate_sel(ctrl_r[sflg_pkg::CTRL_RATE_LO +: 2]),
    .clk_rise(clk_rise),
    .clk_fall(clk_fall),
    .sel_active(sel_active),
    .sdi(sdi),
    .sclk_out(sh_sclk),
    .sdo(sh_sdo),
    .busy(sh_busy),
    .done(sh_done),
    .rx_data(sh_rx)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transfer-done flag; hardware set wins over any clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else if (sh_done) begin
      done_r <= 1'b1;
    end else if (int_ack) begin
      done_r <= 1'b0;
    end else if (wr_stat && !reg_wdata[sflg_pkg::STAT_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // Write-collision flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      write_collision_flag_r <= 1'b0;
    end else if (write_collision_flag_set) begin
      write_collision_flag_r <= 1'b1;
    end else if (wr_data) begin
      write_collision_flag_r <= 1'b0;
    end else if (wr_stat && !reg_wdata[sflg_pkg::STAT_WRITE_COLLISION_FLAG]) begin
      write_collision_flag_r <= 1'b0;
    end
  end

  // Mode-fault flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      modf_r <= 1'b0;
    end else if (modf_set) begin
      modf_r <= 1'b1;
    end else if (wr_stat && !reg_wdata[sflg_pkg::STAT_MODF]) begin
      modf_r <= 1'b0;
    end
  end

  // Receive buffer full and overrun flags
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxf_r <= 1'b0;
    end else if (sh_done) begin
      rxf_r <= 1'b1;
    end else if (rd_data) begin
      rxf_r <= 1'b0;
    end else if (wr_stat && !reg_wdata[sflg_pkg::STAT_RXF]) begin
      rxf_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ovr_r <= 1'b0;
    end else if (sh_done && rxf_r) begin
      ovr_r <= 1'b1;
    end else if (rd_data) begin
      ovr_r <= 1'b0;
    end else if (wr_stat && !reg_wdata[sflg_pkg::STAT_OVR]) begin
      ovr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky event bits, cleared by writing one; a new event wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evt_r <= sflg_pkg::EVT_RST;
    end else begin
      if (wr_evt) begin
        evt_r <= evt_r & ~reg_wdata[2:0];
      end
      if (sh_done) begin
        evt_r[sflg_pkg::EVT_DONE] <= 1'b1;
      end
      if (write_collision_flag_set) begin
        evt_r[sflg_pkg::EVT_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (modf_set) begin
        evt_r[sflg_pkg::EVT_MODF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask_r <= sflg_pkg::EVT_RST;
    end else if (wr_mask) begin
      mask_r <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read side
  always_comb begin
    stat_view = 8'h00;
    stat_view[sflg_pkg::STAT_DONE] = done_r;
    stat_view[sflg_pkg::STAT_WRITE_COLLISION_FLAG] = write_collision_flag_r;
    stat_view[sflg_pkg::STAT_MODF] = modf_r;
    stat_view[sflg_pkg::STAT_OVR] = ovr_r;
    stat_view[sflg_pkg::STAT_RXF] = rxf_r;
    stat_view[sflg_pkg::STAT_BUSY] = sh_busy;
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      sflg_pkg::ADDR_CTRL: rd_mux = ctrl_r;
      sflg_pkg::ADDR_STAT: rd_mux = stat_view;
      sflg_pkg::ADDR_DATA: rd_mux = 8'(sh_rx);
      sflg_pkg::ADDR_EVT: rd_mux = {5'h00, evt_r};
      sflg_pkg::ADDR_MASK: rd_mux = {5'h00, mask_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // Data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (!rst_n || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered so clock and data keep their alignment
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      sclk_oe_n <= 1'b1;
      mosi_oe_n <= 1'b1;
      miso_oe_n <= 1'b1;
    end else begin
      sclk_o <= sh_sclk;
      mosi_o <= sh_sdo;
      miso_o <= sh_sdo;
      sclk_oe_n <= !(port_en && master);
      mosi_oe_n <= !(port_en && master);
      miso_oe_n <= !(port_en && !master && sel_active);
    end
  end
endmodule

//--- bench/sflg_top_assertions.sv
/*
  Port checker for the serial port flag block.
  Assumes it is bound to every sflg_top instance.
*/
`timescale 1ns/1ps
module sflg_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic sclk_o,
  input wire logic sclk_oe_n,
  input wire logic miso_oe_n,
  input wire logic ss_n_i
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [3:0] rise_r;
  // Restart on every data write, so a write dropped while busy also restarts the count mid-burst
  always_ff @(posedge clock) begin
    if (!rst_n || (reg_wr && reg_addr == sflg_pkg::ADDR_DATA)) rise_r <= 4'h0;
    else if (sclk_o && !$past(sclk_o)) rise_r <= rise_r + 4'h1;
  end
  sequence s_ctrl_wr_rd;
    reg_wr && reg_addr == sflg_pkg::ADDR_CTRL && !(reg_wdata[6] && reg_wdata[4] && !reg_wdata[5])
    ##1 reg_rd && reg_addr == sflg_pkg::ADDR_CTRL;
  endsequence
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'hC0 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_low_zero: assert property (
    reg_rd && reg_addr == sflg_pkg::ADDR_STAT |=> reg_rdata[1:0] == 2'b00)
    else $error("status low bits not zero");
  a_ctrl_read_back: assert property (
    s_ctrl_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & sflg_pkg::CTRL_WMASK))
    else $error("control read back differs");
  a_irq_fall_cause: assert property ($fell(irq) |->
    ($past(reg_wr, 2) && $past(reg_addr, 2) >= 8'hBF) || ($past(reg_wr) && $past(reg_addr) >= 8'hBF))
    else $error("interrupt dropped without clear");
  a_sclk_rise_driven: assert property ($rose(sclk_o) |-> !sclk_oe_n)
    else $error("serial clock rose while not driven");
  a_burst_bounded: assert property (rise_r <= 4'h8)
    else $error("more than eight clock pulses");
  a_miso_en_select: assert property ($fell(miso_oe_n) |->
    !$past(ss_n_i, 2) || !$past(ss_n_i, 3) || !$past(ss_n_i, 4))
    else $error("slave output enabled without select");
endmodule
bind sflg_top sflg_chk u_sflg_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n), .miso_oe_n(miso_oe_n), .ss_n_i(ss_n_i));

//--- bench/sflg_peer.sv
/*
  Behavioural slave device on the far side of the port.
  Assumes clock idle low, sample on rise, change on fall, MSB first.
*/
`timescale 1ns/1ps
module sflg_peer (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sh = 8'h00;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  always @(negedge sel_n) begin
    sh = tx_byte;
    miso = tx_byte[7];
  end
  always @(posedge sclk) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sclk) if (!sel_n) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
  // Released line must not look like held data
  always @(posedge sel_n) miso = ~miso;
endmodule

//--- bench/sflg_top_bench.sv
/*
  Register level bench of the serial port flag block.
  Assumes a slave peer in master mode and a 125 ns link clock as slave.
*/
`timescale 1ns/1ps
module sflg_top_bench;
  localparam logic [7:0] CT = sflg_pkg::ADDR_CTRL;
  localparam logic [7:0] ST = sflg_pkg::ADDR_STAT;
  localparam logic [7:0] DT = sflg_pkg::ADDR_DATA;
  localparam logic [7:0] EV = sflg_pkg::ADDR_EVT;
  localparam logic [7:0] MK = sflg_pkg::ADDR_MASK;
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, int_ack = 0, ss_n_i = 1;
  logic sel_n = 1, lk_sclk = 0, lk_mosi = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, ptx = 0, reg_rdata, rv, prx, got;
  logic irq, sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, p_miso;
  int err_total = 0, comparisons = 0;
  always #4 clock = ~clock;
  sflg_top u_sflg_top (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .int_ack(int_ack), .irq(irq), .sclk_i(sclk_oe_n ? lk_sclk : sclk_o), .sclk_o(sclk_o),
    .sclk_oe_n(sclk_oe_n), .mosi_i(mosi_oe_n ? lk_mosi : mosi_o), .mosi_o(mosi_o),
    .mosi_oe_n(mosi_oe_n), .miso_i(p_miso), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .ss_n_i(ss_n_i));
  sflg_peer u_sflg_peer (.sclk(sclk_o), .mosi(mosi_o), .sel_n(sel_n), .tx_byte(ptx),
    .miso(p_miso), .rx_byte(prx));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task idle(input int n);
    reg_wr <= 0;
    reg_rd <= 0;
    repeat (n) @(posedge clock);
  endtask
  // Leaves the strobe up so writes can run back to back
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    reg_rd <= 0;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    reg_addr <= a;
    reg_rd <= 1;
    reg_wr <= 0;
    @(posedge clock);
    reg_rd <= 0;
    @(posedge clock);
    rv = reg_rdata;
    if (m !== 8'h00) chk($sformatf("reg %h", a), e & m, rv & m);
  endtask
  task wait_idle;
    rv = 8'h04;
    for (int i = 0; i < 40 && rv[2] !== 1'b0; i++) rd(ST, 8'h00, 8'h00);
    if (rv[2] !== 1'b0) chk("busy end", 8'h00, rv);
  endtask
  task xfer(input logic [7:0] p, input logic [7:0] d);
    sel_n <= 1;
    ptx <= p;
    idle(2);
    sel_n <= 0;
    idle(1);
    wr(DT, d);
  endtask
  task slave(input logic [7:0] b);
    ss_n_i <= 0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      lk_mosi = b[i];
      #62.5 lk_sclk = 1;
      got[i] = miso_o;
      #62.5 lk_sclk = 0;
    end
    lk_mosi = ~lk_mosi;
    #100 ss_n_i <= 1;
    @(posedge clock);
  endtask
  task end_of_test;
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    idle(10);
    rst_n <= 1;
    idle(1);
    rd(ST, 8'h00, 8'hFF);
    rd(CT, 8'h00, 8'hFF);
    rd(8'hC5, 8'h00, 8'hFF);
    wr(MK, 8'h07);
    wr(CT, 8'h70);
    rd(CT, 8'h70, 8'hFF);
    chk("pin oe", 8'h00, {6'h00, sclk_oe_n, mosi_oe_n});
    xfer(8'hA5, 8'h3C);
    wr(DT, 8'h11);
    rd(ST, 8'h44, 8'h44);
    wait_idle;
    rd(ST, 8'hC8, 8'hFC);
    chk("peer rx", 8'h3C, prx);
    chk("irq", 8'h01, {7'h00, irq});
    rd(DT, 8'hA5, 8'hFF);
    rd(ST, 8'hC0, 8'hFC);
    wr(ST, 8'h7F);
    rd(ST, 8'h40, 8'hFC);
    xfer(8'h96, 8'h0F);
    rd(ST, 8'h04, 8'h44);
    wait_idle;
    xfer(8'h69, 8'hF0);
    wait_idle;
    rd(ST, 8'h98, 8'hFC);
    wr(ST, 8'hEF);
    rd(ST, 8'h88, 8'hFC);
    rd(DT, 8'h69, 8'hFF);
    rd(ST, 8'h80, 8'hFC);
    int_ack <= 1;
    idle(1);
    int_ack <= 0;
    rd(ST, 8'h00, 8'h80);
    wr(MK, 8'h00);
    idle(3);
    chk("irq", 8'h00, {7'h00, irq});
    wr(MK, 8'h07);
    idle(3);
    chk("irq", 8'h01, {7'h00, irq});
    wr(EV, 8'h07);
    idle(3);
    chk("irq", 8'h00, {7'h00, irq});
    wr(CT, 8'h50);
    ss_n_i <= 0;
    idle(8);
    rd(CT, 8'h00, 8'h70);
    rd(ST, 8'h20, 8'h20);
    chk("pin oe", 8'h03, {6'h00, sclk_oe_n, mosi_oe_n});
    ss_n_i <= 1;
    wr(ST, 8'hDF);
    rd(ST, 8'h00, 8'h20);
    wr(CT, 8'h40);
    wr(DT, 8'hC3);
    idle(1);
    slave(8'h5A);
    idle(4);
    rd(ST, 8'h88, 8'hFC);
    rd(DT, 8'h5A, 8'hFF);
    chk("slave out", 8'hC3, got);
    end_of_test;
  end
  initial begin
    #100000;
    err_total++;
    end_of_test;
  end
endmodule
